// ===== hdl/sscb_pkg.sv
package sscb_pkg;

  localparam int SSCB_WORD_W   = 32;
  localparam int SSCB_SEL_W    = 3;
  localparam int SSCB_INT_W    = 12;
  localparam int SSCB_FRAC_W   = 25;
  localparam int SSCB_FMSB_W   = 12;
  localparam int SSCB_FLSB_W   = 13;
  localparam int SSCB_RCNT_W   = 5;
  localparam int SSCB_MON_W    = 4;
  localparam int SSCB_CPI_W    = 4;

  // Latch select codes
  localparam logic [2:0] SSCB_SEL_INTFRAC = 3'h0;
  localparam logic [2:0] SSCB_SEL_FLOW    = 3'h1;
  localparam logic [2:0] SSCB_SEL_RDIV    = 3'h2;
  localparam logic [2:0] SSCB_SEL_FUNC    = 3'h3;
  localparam logic [2:0] SSCB_SEL_TEST    = 3'h4;

  // Field positions (low bit of each field)
  localparam int SSCB_MON_LSB    = 27;
  localparam int SSCB_INT_LSB    = 15;
  localparam int SSCB_FMSB_LSB   = 3;
  localparam int SSCB_FLSB_LSB   = 15;
  localparam int SSCB_RCNT_LSB   = 15;
  localparam int SSCB_DBL_BIT    = 20;
  localparam int SSCB_HALF_BIT   = 21;
  localparam int SSCB_CPI_LSB    = 24;
  localparam int SSCB_CSR_BIT    = 28;
  localparam int SSCB_SDRST_BIT  = 14;
  localparam int SSCB_PD_BIT     = 5;
  localparam int SSCB_TRI_BIT    = 4;
  localparam int SSCB_CRST_BIT   = 3;

  // Whole divide limits
  localparam logic [11:0] SSCB_INT_MIN = 12'h017;
  localparam logic [11:0] SSCB_INT_MAX = 12'hfff;

  // Monitor select codes
  localparam logic [3:0] SSCB_MON_TRI   = 4'h0;
  localparam logic [3:0] SSCB_MON_HIGH  = 4'h1;
  localparam logic [3:0] SSCB_MON_LOW   = 4'h2;
  localparam logic [3:0] SSCB_MON_RDIV  = 4'h3;
  localparam logic [3:0] SSCB_MON_NDIV  = 4'h4;

  // Settings in effect; rcnt, doubler, halver, cpi and the thirteen low fraction bits pass through double buffering
  typedef struct packed {
    logic [SSCB_MON_W-1:0]  mon_sel;
    logic [SSCB_INT_W-1:0]  int_val;
    logic [SSCB_FRAC_W-1:0] frac_val;
    logic [SSCB_RCNT_W-1:0] rcnt;
    logic                   doubler;
    logic                   halver;
    logic [SSCB_CPI_W-1:0]  cpi;
    logic                   csr_en;
  } sscb_cfg_t;

endpackage : sscb_pkg

// ===== hdl/sscb_bank.sv
`timescale 1ns/1ps
// How it works
// - Shift data in on each serial clock rise
// - Load strobe rise copies word to one latch
// - Low three bits choose the latch
// - Codes zero to four map five words
// - Buffered fields apply on next integer word
// - Monitor source from integer word bits 30:27
// - Whole divide bits 26:15, range 23..4095
// - Numerator is twelve high plus thirteen low bits
// - Ratio is whole plus numerator over 2^25
// - Reference count bits 19:15 divide 1..32
// - Detector rate uses doubler, count, halver
// - Reference, feedback and fraction counters loaded
// - Modulator resets per integer write unless disabled
// - Chip enable low powers down, pump tristated
module sscb_bank
  import sscb_pkg::*;
#(
  parameter int INT_W  = SSCB_INT_W,
  parameter int FRAC_W = SSCB_FRAC_W
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_data,
  input  wire logic                  load_strobe,
  input  wire logic                  chip_enable,
  input  wire logic                  reference_input,
  input  wire logic                  feedback_input,
  input  wire logic                  lock_detect,
  output logic                       monitor_output,
  output logic                       monitor_output_oe,
  output logic                       pump_enable,
  output logic                       power_down,
  output logic                       phase_ref_pulse,
  output logic                       feedback_pulse,
  output logic                       modulator_reset,
  output logic [FRAC_W-1:0]          frac_accum,
  output sscb_cfg_t                  active_cfg,
  output logic [SSCB_WORD_W-1:0]     test_word_q
);

  // Reset release and pin synchronisers
  logic                   rst_s1_q, rst_n;
  logic [1:0]             le_sync_q, ce_sync_q, ref_sync_q, fb_sync_q, lk_sync_q;
  logic                   le_d1_q, ref_d1_q, fb_d1_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // One two-stage synchroniser per pin; only stage two is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      le_sync_q <= 2'h0;
    end else begin
      le_sync_q <= {le_sync_q[0], load_strobe};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_sync_q <= 2'h0;
    end else begin
      ce_sync_q <= {ce_sync_q[0], chip_enable};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_sync_q <= 2'h0;
    end else begin
      ref_sync_q <= {ref_sync_q[0], reference_input};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_sync_q <= 2'h0;
    end else begin
      fb_sync_q <= {fb_sync_q[0], feedback_input};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_sync_q <= 2'h0;
    end else begin
      lk_sync_q <= {lk_sync_q[0], lock_detect};
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      le_d1_q  <= 1'b0;
      ref_d1_q <= 1'b0;
      fb_d1_q  <= 1'b0;
    end else begin
      le_d1_q  <= le_sync_q[1];
      ref_d1_q <= ref_sync_q[1];
      fb_d1_q  <= fb_sync_q[1];
    end
  end

  // Serial clock domain: shift register only. The serial clock may stop
  // between words, so the word is held here and sampled by clk after the
  // synchronised strobe edge; the host keeps it still while the strobe is high.
  logic [SSCB_WORD_W-1:0] shift_q;

  always_ff @(posedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[SSCB_WORD_W-2:0], serial_data};
    end
  end

  logic                   load_rise;
  logic [SSCB_WORD_W-1:0] word;
  logic [2:0]             sel;
  assign load_rise = le_sync_q[1] & ~le_d1_q;
  assign word      = shift_q;
  assign sel       = word[SSCB_SEL_W-1:0];

  // Latches
  logic [SSCB_WORD_W-1:0] w_int_q, w_flow_q, w_rdiv_q, w_func_q;
  logic                   int_wr;
  assign int_wr = load_rise & (sel == SSCB_SEL_INTFRAC);

  // Codes 5 to 7 match none of these, so no latch moves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_int_q <= '0;
    end else if (int_wr) begin
      w_int_q <= word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_flow_q <= '0;
    end else if (load_rise && (sel == SSCB_SEL_FLOW)) begin
      w_flow_q <= word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_rdiv_q <= '0;
    end else if (load_rise && (sel == SSCB_SEL_RDIV)) begin
      w_rdiv_q <= word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_func_q <= '0;
    end else if (load_rise && (sel == SSCB_SEL_FUNC)) begin
      w_func_q <= word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_word_q <= '0;
    end else if (load_rise && (sel == SSCB_SEL_TEST)) begin
      test_word_q <= word;
    end
  end

  // Double-buffered copy: pending fields move on an integer word write
  logic [SSCB_FLSB_W-1:0] flsb_q;
  logic [SSCB_RCNT_W-1:0] rcnt_q;
  logic                   dbl_q, half_q;
  logic [SSCB_CPI_W-1:0]  cpi_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flsb_q <= '0;
    end else if (int_wr) begin
      flsb_q <= w_flow_q[SSCB_FLSB_LSB +: SSCB_FLSB_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= '0;
    end else if (int_wr) begin
      rcnt_q <= w_rdiv_q[SSCB_RCNT_LSB +: SSCB_RCNT_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbl_q <= 1'b0;
    end else if (int_wr) begin
      dbl_q <= w_rdiv_q[SSCB_DBL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else if (int_wr) begin
      half_q <= w_rdiv_q[SSCB_HALF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpi_q <= '0;
    end else if (int_wr) begin
      cpi_q <= w_rdiv_q[SSCB_CPI_LSB +: SSCB_CPI_W];
    end
  end

  always_comb begin
    active_cfg.mon_sel  = w_int_q[SSCB_MON_LSB +: SSCB_MON_W];
    active_cfg.int_val  = w_int_q[SSCB_INT_LSB +: SSCB_INT_W];
    active_cfg.frac_val = {w_int_q[SSCB_FMSB_LSB +: SSCB_FMSB_W], flsb_q};
    active_cfg.rcnt     = rcnt_q;
    active_cfg.doubler  = dbl_q;
    active_cfg.halver   = half_q;
    active_cfg.cpi      = cpi_q;
    active_cfg.csr_en   = w_rdiv_q[SSCB_CSR_BIT];
  end

  // Power-down: pin or software bit; counters held at load state
  logic hold;
  assign power_down  = ~ce_sync_q[1] | w_func_q[SSCB_PD_BIT];
  assign hold        = power_down | w_func_q[SSCB_CRST_BIT];
  assign pump_enable = ~power_down & ~w_func_q[SSCB_TRI_BIT];

  // Reference path: doubler counts both edges, R counter, optional halver
  logic       ref_edge;
  logic [4:0] rcnt_cnt_q;
  logic       half_tog_q;
  logic       r_tick;
  assign ref_edge = dbl_q ? (ref_sync_q[1] ^ ref_d1_q) : (ref_d1_q & ~ref_sync_q[1]);
  assign r_tick   = ref_edge & (rcnt_cnt_q == 5'h00);

  // A field of zero divides by 32, giving the full 1..32 span
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_cnt_q <= '0;
    end else if (hold) begin
      rcnt_cnt_q <= '0;
    end else if (ref_edge) begin
      rcnt_cnt_q <= (rcnt_cnt_q == 5'h00) ? rcnt_q - 5'h01 : rcnt_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_tog_q <= 1'b0;
    end else if (hold) begin
      half_tog_q <= 1'b0;
    end else if (r_tick) begin
      half_tog_q <= ~half_tog_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ref_pulse <= 1'b0;
    end else if (hold) begin
      phase_ref_pulse <= 1'b0;
    end else begin
      phase_ref_pulse <= r_tick & (~half_q | half_tog_q);
    end
  end

  // Feedback path: whole-divide counter with fraction accumulator carry
  logic [INT_W-1:0]  n_cnt_q;
  logic [FRAC_W:0]   acc_sum;
  logic              fb_edge, n_tick, int_ok;
  assign fb_edge = fb_sync_q[1] & ~fb_d1_q;
  assign n_tick  = fb_edge & (n_cnt_q == '0);
  assign int_ok  = (active_cfg.int_val >= SSCB_INT_MIN) && (active_cfg.int_val <= SSCB_INT_MAX);
  assign acc_sum = {1'b0, frac_accum} + {1'b0, active_cfg.frac_val};
  assign modulator_reset = int_wr & ~w_func_q[SSCB_SDRST_BIT];

  // Out-of-range whole divide holds the counter rather than run a bad ratio
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_cnt_q <= '0;
    end else if (hold || !int_ok) begin
      n_cnt_q <= '0;
    end else if (fb_edge) begin
      // Carry out stretches this cycle by one: ratio int + frac/2^25
      n_cnt_q <= (n_cnt_q == '0) ? (active_cfg.int_val - INT_W'(1) + INT_W'(acc_sum[FRAC_W]))
                                 : n_cnt_q - INT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_accum <= '0;
    end else if (hold || !int_ok) begin
      frac_accum <= '0;
    end else if (modulator_reset) begin
      frac_accum <= '0;
    end else if (n_tick) begin
      frac_accum <= acc_sum[FRAC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feedback_pulse <= 1'b0;
    end else if (hold || !int_ok) begin
      feedback_pulse <= 1'b0;
    end else begin
      feedback_pulse <= n_tick;
    end
  end

  // Monitor output mux
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_output_oe <= 1'b0;
    end else begin
      monitor_output_oe <= (active_cfg.mon_sel != SSCB_MON_TRI);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_output <= 1'b0;
    end else begin
      case (active_cfg.mon_sel)
        SSCB_MON_HIGH: monitor_output <= 1'b1;
        SSCB_MON_LOW:  monitor_output <= 1'b0;
        SSCB_MON_RDIV: monitor_output <= phase_ref_pulse;
        SSCB_MON_NDIV: monitor_output <= feedback_pulse;
        default:       monitor_output <= lk_sync_q[1];
      endcase
    end
  end

endmodule : sscb_bank

// ===== test/sscb_host.sv
`timescale 1ns/1ps
module sscb_host (
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Clock stands still between frames
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial_data = w[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    serial_data = ~w[0];
    #20 load_strobe = 1'b1;
    #200 load_strobe = 1'b0;
    #80;
  endtask : send
endmodule : sscb_host

// ===== test/sscb_bank_sva.sv
`timescale 1ns/1ps
module sscb_bank_sva
  import sscb_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              load_strobe,
  input wire logic              chip_enable,
  input wire logic              monitor_output,
  input wire logic              monitor_output_oe,
  input wire logic              pump_enable,
  input wire logic              power_down,
  input wire logic              modulator_reset,
  input wire sscb_cfg_t         active_cfg,
  input wire logic [31:0]       test_word_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_mon(logic [3:0] c);
    (active_cfg.mon_sel == c)[*2];
  endsequence
  sequence s_ce_off;
    !chip_enable[*3];
  endsequence
  property p_cfg_quiet; $changed(active_cfg) |-> load_strobe; endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("config moved without load");
  property p_test_quiet; $changed(test_word_q) |-> load_strobe; endproperty
  a_test_quiet: assert property (p_test_quiet)
    else $error("test word moved without load");
  property p_modrst; modulator_reset |-> load_strobe ##1 !modulator_reset; endproperty
  a_modrst: assert property (p_modrst)
    else $error("modulator reset not a load pulse");
  // Holds only while every change of the reference count rides with a new whole divide
  property p_buffered; $changed(active_cfg.rcnt) |-> $changed(active_cfg.int_val); endproperty
  a_buffered: assert property (p_buffered)
    else $error("buffered field applied early");
  property p_pump; pump_enable |-> !power_down; endproperty
  a_pump: assert property (p_pump)
    else $error("pump on while powered down");
  property p_ce; s_ce_off |-> power_down && !pump_enable; endproperty
  a_ce: assert property (p_ce)
    else $error("chip enable low ignored");
  property p_mon_tri; s_mon(SSCB_MON_TRI) |-> !monitor_output_oe; endproperty
  a_mon_tri: assert property (p_mon_tri)
    else $error("monitor driven when off");
  property p_mon_high; s_mon(SSCB_MON_HIGH) |-> monitor_output_oe && monitor_output; endproperty
  a_mon_high: assert property (p_mon_high)
    else $error("monitor not high");
endmodule : sscb_bank_sva

// ===== test/sscb_bank_tb.sv
`timescale 1ns/1ps
module sscb_bank_tb;
  import sscb_pkg::*;
  logic        clk, resetn, chip_enable, reference_input, feedback_input, lock_detect;
  logic        serial_clk, serial_data, load_strobe, monitor_output, monitor_output_oe;
  logic        pump_enable, power_down, phase_ref_pulse, feedback_pulse, modulator_reset;
  logic [24:0] frac_accum;
  logic [31:0] test_word_q;
  sscb_cfg_t   active_cfg;
  logic [5:0]  fn [3] = '{6'h23, 6'h13, 6'h03};
  int          fail_count, num_checks, cycles;
  sscb_bank DUT (.clk, .resetn, .serial_clk, .serial_data, .load_strobe, .chip_enable, .reference_input,
    .feedback_input, .lock_detect, .monitor_output, .monitor_output_oe, .pump_enable, .power_down,
    .phase_ref_pulse, .feedback_pulse, .modulator_reset, .frac_accum, .active_cfg, .test_word_q);
  sscb_host host (.serial_clk, .serial_data, .load_strobe);
  always #20 clk = ~clk;
  always @(negedge clk) begin
    reference_input <= ~reference_input;
    feedback_input  <= ~feedback_input;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Cycles between two pulses, sampled away from the launching edge
  task automatic gap(input string n, input bit s, input int e);
    int          t;
    logic [24:0] a;
    t = 0;
    do @(negedge clk); while ((s ? feedback_pulse : phase_ref_pulse) !== 1'b1);
    a = frac_accum;
    do begin
      @(negedge clk);
      t++;
    end while ((s ? feedback_pulse : phase_ref_pulse) !== 1'b1);
    chk(n, e, t);
    if (s) chk("frac_step", 32'h1abc, {7'h0, frac_accum - a});
  endtask : gap
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    clk             = 1'b0;
    resetn          = 1'b0;
    chip_enable     = 1'b0;
    reference_input = 1'b0;
    feedback_input  = 1'b0;
    lock_detect     = 1'b0;
    cycles          = 0;
    fail_count      = 0;
    num_checks      = 0;
    repeat (2) @(negedge clk);
    chk("power_down", 32'h1, {31'h0, power_down});
    resetn      = 1'b1;
    chip_enable = 1'b1;
    repeat (6) @(negedge clk);
    host.send({4'h0, 13'h1abc, 12'h000, 3'h1});
    host.send({3'h0, 1'b1, 4'h7, 2'h0, 2'h3, 5'h05, 12'h000, 3'h2});
    chk("csr", 32'h1, {31'h0, active_cfg.csr_en});
    chk("pending", 32'h0, {2'h0, active_cfg.frac_val, active_cfg.rcnt});
    host.send({1'b0, 4'h1, 12'h123, 12'habc, 3'h0});
    chk("int", 32'h123, {20'h0, active_cfg.int_val});
    chk("frac", {7'h0, 12'habc, 13'h1abc}, {7'h0, active_cfg.frac_val});
    chk("buffered", {21'h0, 5'h05, 2'h3, 4'h7}, {21'h0, active_cfg.rcnt, active_cfg.doubler,
      active_cfg.halver, active_cfg.cpi});
    chk("monitor", 32'h3, {30'h0, monitor_output_oe, monitor_output});
    host.send(32'h1234_5674);
    chk("test_word", 32'h1234_5674, test_word_q);
    for (int k = 5; k < 8; k++) begin
      host.send({29'h0aaa_aaaa, 3'(k)});
      chk("ignored", 32'h1234_5674, test_word_q);
    end
    chk("int kept", 32'h123, {20'h0, active_cfg.int_val});
    host.send({1'b0, 4'h5, 12'h123, 12'habc, 3'h0});
    @(negedge clk);
    lock_detect = 1'b1;
    repeat (4) @(negedge clk);
    chk("lock", 32'h1, {31'h0, monitor_output});
    host.send({1'b0, 4'h0, 12'h017, 12'h000, 3'h0});
    chk("tri", 32'h017, {19'h0, monitor_output_oe, active_cfg.int_val});
    // Power-down, pump off, then normal
    for (int i = 0; i < 3; i++) begin
      host.send({26'h0, fn[i]});
      chk("pump", {30'h0, fn[i][5], fn[i][5:4] == 2'h0}, {30'h0, power_down, pump_enable});
    end
    gap("ref_period", 1'b0, 10);
    gap("fb_period", 1'b1, 46);
    @(negedge clk);
    chip_enable = 1'b0;
    repeat (4) @(negedge clk);
    chk("chip_enable", 32'h1, {31'h0, power_down});
    end_sim();
  end
endmodule : sscb_bank_tb
bind sscb_bank sscb_bank_sva u_sva (.clk, .resetn, .load_strobe, .chip_enable, .monitor_output,
  .monitor_output_oe, .pump_enable, .power_down, .modulator_reset, .active_cfg, .test_word_q);
